/* logic/adc_readout.sv */
// Function
// - mode bits pick calibration type and length
// - reset loads control register default
// - mode pin high: device drives serial clock
// - reads reach all; writes only ctrl/cal
// - select high: output/cal; low: control
// - new word drives ready low
// - ready high after last word bit read
// - unread: ready stays low, newest word kept
// - word arriving during output read discarded
// - ctrl/cal reads leave ready untouched
// - output read only while ready low
// - frame low enables clock, shows MSB
// - bits shift on falling serial clock edges
// - ready rise ends clock and data drive
// - ready low signals calibration end
// - background mode divides word rate by six
// - mode pin low: serial clock is input
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module adc_readout
	import adc_readout_pkg::*;
(
	input  wire logic                  CLOCK,
	input  wire logic                  RST,
	input  wire logic [AXI_ADDR_W-1:0] AWADDR,
	input  wire logic                  AWVALID,
	output logic                       AWREADY,
	input  wire logic [AXI_DATA_W-1:0] WDATA,
	input  wire logic [3:0]            WSTRB,
	input  wire logic                  WVALID,
	output logic                       WREADY,
	output logic [1:0]                 BRESP,
	output logic                       BVALID,
	input  wire logic                  BREADY,
	input  wire logic [AXI_ADDR_W-1:0] ARADDR,
	input  wire logic                  ARVALID,
	output logic                       ARREADY,
	output logic [AXI_DATA_W-1:0]      RDATA,
	output logic [1:0]                 RRESP,
	output logic                       RVALID,
	input  wire logic                  RREADY,
	input  wire logic [WORD_W-1:0]     SAMPLE_DATA,
	input  wire logic                  SAMPLE_STROBE,
	input  wire logic                  MODE_PIN,
	input  wire logic                  READ_FRAME_N,
	input  wire logic                  REGISTER_SELECT,
	input  wire logic                  SCLK_IN,
	output logic                       SCLK_OUT,
	output logic                       SCLK_OE,
	output logic                       SERIAL_DATA_PIN_OUT,
	output logic                       SERIAL_DATA_PIN_OE,
	output logic                       WORD_READY_N
);

	// ==========================================================
	// state
	logic [WORD_W-1:0]     ctrl_reg, ctrl_next, offs_reg, offs_next, gain_reg, gain_next;
	logic [WORD_W-1:0]     word_reg, word_next, shift_reg, shift_next;
	logic                  ready_n_reg, ready_n_next, cal_busy_reg, cal_busy_next;
	logic [3:0]            cal_cnt_reg, cal_cnt_next;
	logic [2:0]            bg_cnt_reg, bg_cnt_next;
	logic [AXI_ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic [AXI_DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
	logic [3:0]            wstrb_reg, wstrb_next;
	logic                  aw_got_reg, aw_got_next, w_got_reg, w_got_next;
	logic                  awready_reg, awready_next, wready_reg, wready_next;
	logic                  bvalid_reg, bvalid_next, arready_reg, arready_next;
	logic                  rvalid_reg, rvalid_next;
	logic [1:0]            bresp_reg, bresp_next, rresp_reg, rresp_next;
	ser_state_t            state_reg, state_next;
	logic [4:0]            bits_reg, bits_next;
	logic [2:0]            half_reg, half_next;
	logic                  out_rd_reg, out_rd_next, sclk_reg, sclk_next;
	logic                  sclk_oe_reg, sclk_oe_next, sdo_oe_reg, sdo_oe_next;
	logic [3:0]            sync1_reg, sync2_reg;
	logic                  frame_d_reg, sclk_d_reg;
	logic                  mode_s, frame_s, sel_s, sclk_s;
	logic                  out_done, cal_start, word_event, rise, fall;

	assign mode_s  = sync2_reg[0];
	assign frame_s = sync2_reg[1];
	assign sel_s   = sync2_reg[2];
	assign sclk_s  = sync2_reg[3];

	// ==========================================================
	// pin synchronisers: first stage feeds only the second
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			sync1_reg   <= 4'hA;
			sync2_reg   <= 4'hA;
			frame_d_reg <= 1'b1;
			sclk_d_reg  <= 1'b1;
		end else begin
			sync1_reg   <= {SCLK_IN, REGISTER_SELECT, READ_FRAME_N, MODE_PIN};
			sync2_reg   <= sync1_reg;
			frame_d_reg <= frame_s;
			sclk_d_reg  <= sclk_s;
		end
	end

	// byte-lane merge for 24-bit registers; the top lane has no storage
	function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old,
		input logic [AXI_DATA_W-1:0] data, input logic [3:0] strb);
		logic [WORD_W-1:0] res;
		res = old;
		for (int i = 0; i < 3; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// ==========================================================
	// register bus, conversion words and calibration
	always_comb begin
		logic          do_write;
		logic [3:0]    per;
		do_write     = aw_got_reg && w_got_reg && !bvalid_reg;
		per          = PER_SELF;
		ctrl_next    = ctrl_reg;
		offs_next    = offs_reg;
		gain_next    = gain_reg;
		word_next    = word_reg;
		ready_n_next = ready_n_reg;
		cal_busy_next = cal_busy_reg;
		cal_cnt_next = cal_cnt_reg;
		bg_cnt_next  = bg_cnt_reg;
		awaddr_next  = awaddr_reg;
		wdata_next   = wdata_reg;
		wstrb_next   = wstrb_reg;
		aw_got_next  = aw_got_reg;
		w_got_next   = w_got_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		cal_start    = 1'b0;
		word_event   = 1'b0;
		if (AWVALID && awready_reg) begin
			awaddr_next = AWADDR;
			aw_got_next = 1'b1;
		end
		if (WVALID && wready_reg) begin
			wdata_next = WDATA;
			wstrb_next = WSTRB;
			w_got_next = 1'b1;
		end
		if (BREADY && bvalid_reg) begin
			bvalid_next = 1'b0;
		end
		// converter side: cal counts output periods, words when idle and at the last cal period
		if (SAMPLE_STROBE) begin
			if (cal_busy_reg) begin
				cal_cnt_next = cal_cnt_reg - 4'h1;
				if (cal_cnt_reg == 4'h1) begin
					cal_busy_next = 1'b0;
					word_event    = 1'b1;
					case (ctrl_reg[MODE_MSB:MODE_LSB])
						MODE_SYS_FULL: gain_next = SAMPLE_DATA;
						default:       offs_next = SAMPLE_DATA;
					endcase
				end
			end else if (ctrl_reg[MODE_MSB:MODE_LSB] == MODE_BACKGND) begin
				bg_cnt_next = (bg_cnt_reg == BG_DIVIDE - 3'h1) ? 3'h0 : bg_cnt_reg + 3'h1;
				word_event  = (bg_cnt_reg == BG_DIVIDE - 3'h1);
			end else begin
				word_event = 1'b1;
			end
		end
		// a word during an output read is dropped: nothing signals it
		if (word_event && !out_rd_reg) begin
			word_next    = SAMPLE_DATA;
			ready_n_next = 1'b0;
		end
		if (out_done) begin
			ready_n_next = 1'b1;
		end
		// writes reach only control and calibration registers
		if (do_write) begin
			aw_got_next = 1'b0;
			w_got_next  = 1'b0;
			bvalid_next = 1'b1;
			bresp_next  = RESP_OKAY;
			case (awaddr_reg)
				ADDR_CTRL: begin
					ctrl_next = merge(ctrl_reg, wdata_reg, wstrb_reg);
					case (ctrl_next[MODE_MSB:MODE_LSB])
						MODE_SELF:     per = PER_SELF;
						MODE_SYS_ZERO: per = PER_SYS;
						MODE_SYS_FULL: per = PER_SYS;
						MODE_SYS_OFFS: per = PER_SYS_OFFS;
						default:       per = 4'h0;
					endcase
					bg_cnt_next = 3'h0;
					if (per != 4'h0) begin
						cal_start     = 1'b1;
						cal_busy_next = 1'b1;
						cal_cnt_next  = per;
						ready_n_next  = 1'b1;
					end
				end
				ADDR_OFFS: offs_next  = merge(offs_reg, wdata_reg, wstrb_reg);
				ADDR_GAIN: gain_next  = merge(gain_reg, wdata_reg, wstrb_reg);
				default:   bresp_next = RESP_SLVERR;
			endcase
		end
		awready_next = !aw_got_next && !bvalid_next;
		wready_next  = !w_got_next && !bvalid_next;
		// reads answer one cycle after the address is taken
		if (RREADY && rvalid_reg) begin
			rvalid_next = 1'b0;
		end
		if (ARVALID && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next  = RESP_OKAY;
			rdata_next  = '0;
			case (ARADDR)
				ADDR_CTRL: rdata_next[WORD_W-1:0] = ctrl_reg;
				ADDR_OFFS: rdata_next[WORD_W-1:0] = offs_reg;
				ADDR_GAIN: rdata_next[WORD_W-1:0] = gain_reg;
				ADDR_DATA: rdata_next[WORD_W-1:0] = word_reg;
				ADDR_STAT: begin
					rdata_next[STAT_READY_BIT] = !ready_n_reg;
					rdata_next[STAT_CAL_BIT]   = cal_busy_reg;
					rdata_next[STAT_XFER_BIT]  = (state_reg != SER_IDLE);
				end
				default: rresp_next = RESP_SLVERR;
			endcase
		end
		arready_next = !rvalid_next;
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			ctrl_reg     <= CTRL_RESET;
			offs_reg     <= OFFS_RESET;
			gain_reg     <= GAIN_RESET;
			word_reg     <= '0;
			ready_n_reg  <= 1'b1;
			cal_busy_reg <= 1'b0;
			cal_cnt_reg  <= 4'h0;
			bg_cnt_reg   <= 3'h0;
			awaddr_reg   <= '0;
			wdata_reg    <= '0;
			wstrb_reg    <= 4'h0;
			aw_got_reg   <= 1'b0;
			w_got_reg    <= 1'b0;
			awready_reg  <= 1'b1;
			wready_reg   <= 1'b1;
			bvalid_reg   <= 1'b0;
			bresp_reg    <= RESP_OKAY;
			arready_reg  <= 1'b1;
			rvalid_reg   <= 1'b0;
			rresp_reg    <= RESP_OKAY;
			rdata_reg    <= '0;
		end else begin
			ctrl_reg     <= ctrl_next;
			offs_reg     <= offs_next;
			gain_reg     <= gain_next;
			word_reg     <= word_next;
			ready_n_reg  <= ready_n_next;
			cal_busy_reg <= cal_busy_next;
			cal_cnt_reg  <= cal_cnt_next;
			bg_cnt_reg   <= bg_cnt_next;
			awaddr_reg   <= awaddr_next;
			wdata_reg    <= wdata_next;
			wstrb_reg    <= wstrb_next;
			aw_got_reg   <= aw_got_next;
			w_got_reg    <= w_got_next;
			awready_reg  <= awready_next;
			wready_reg   <= wready_next;
			bvalid_reg   <= bvalid_next;
			bresp_reg    <= bresp_next;
			arready_reg  <= arready_next;
			rvalid_reg   <= rvalid_next;
			rresp_reg    <= rresp_next;
			rdata_reg    <= rdata_next;
		end
	end

	// ==========================================================
	// serial read framing; external clock edges come from the synchroniser
	always_comb begin
		logic tick;
		tick        = (half_reg == 3'(SCLK_HALF_CYC - 1));
		state_next  = state_reg;
		bits_next   = bits_reg;
		half_next   = half_reg;
		shift_next  = shift_reg;
		out_rd_next = out_rd_reg;
		sclk_next   = sclk_reg;
		sclk_oe_next = 1'b0;
		sdo_oe_next = 1'b0;
		out_done    = 1'b0;
		rise        = mode_s ? tick && state_reg == SER_LOW : !sclk_d_reg && sclk_s;
		fall        = mode_s ? tick && state_reg == SER_HIGH : sclk_d_reg && !sclk_s;
		case (state_reg)
			SER_IDLE: begin
				sclk_next = 1'b0;
				half_next = 3'h0;
				if (frame_d_reg && !frame_s) begin
					bits_next  = BITS_LONG;
					state_next = SER_LOW;
					if (!sel_s) begin
						shift_next = ctrl_reg;
					end else if (ctrl_reg[CALSEL_BIT]) begin
						shift_next = ctrl_reg[CALGAIN_BIT] ? gain_reg : offs_reg;
					end else if (!ready_n_reg) begin
						shift_next  = word_reg;
						out_rd_next = 1'b1;
						bits_next   = ctrl_reg[WL24_BIT] ? BITS_LONG : BITS_SHORT;
					end else begin
						state_next = SER_IDLE;
					end
					sdo_oe_next  = (state_next != SER_IDLE);
					sclk_oe_next = mode_s && (state_next != SER_IDLE);
				end
			end
			default: begin
				// frame high pauses the word; drive stops until it falls again
				if (!frame_s) begin
					sdo_oe_next  = 1'b1;
					sclk_oe_next = mode_s;
					half_next    = tick ? 3'h0 : half_reg + 3'h1;
					if (rise) begin
						state_next = SER_HIGH;
						sclk_next  = 1'b1;
					end else if (fall) begin
						sclk_next = 1'b0;
						if (bits_reg == 5'h1) begin
							state_next   = SER_IDLE;
							out_done     = out_rd_reg;
							out_rd_next  = 1'b0;
							sdo_oe_next  = 1'b0;
							sclk_oe_next = 1'b0;
						end else begin
							shift_next = {shift_reg[WORD_W-2:0], 1'b0};
							bits_next  = bits_reg - 5'h1;
							state_next = SER_LOW;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state_reg   <= SER_IDLE;
			bits_reg    <= 5'h0;
			half_reg    <= 3'h0;
			shift_reg   <= '0;
			out_rd_reg  <= 1'b0;
			sclk_reg    <= 1'b0;
			sclk_oe_reg <= 1'b0;
			sdo_oe_reg  <= 1'b0;
		end else begin
			state_reg   <= state_next;
			bits_reg    <= bits_next;
			half_reg    <= half_next;
			shift_reg   <= shift_next;
			out_rd_reg  <= out_rd_next;
			sclk_reg    <= sclk_next;
			sclk_oe_reg <= sclk_oe_next;
			sdo_oe_reg  <= sdo_oe_next;
		end
	end

	// ==========================================================
	// outputs, each straight from a flip-flop
	assign AWREADY = awready_reg;
	assign WREADY  = wready_reg;
	assign BVALID  = bvalid_reg;
	assign BRESP   = bresp_reg;
	assign ARREADY = arready_reg;
	assign RVALID  = rvalid_reg;
	assign RRESP   = rresp_reg;
	assign RDATA   = rdata_reg;
	assign SCLK_OUT            = sclk_reg;
	assign SCLK_OE             = sclk_oe_reg;
	assign SERIAL_DATA_PIN_OUT = shift_reg[WORD_W-1];
	assign SERIAL_DATA_PIN_OE  = sdo_oe_reg;
	assign WORD_READY_N        = ready_n_reg;

	// ==========================================================
	// checks
	a_idle_hiz: assert property (@(posedge CLOCK) disable iff (RST)
		state_reg == SER_IDLE |=> !SERIAL_DATA_PIN_OE || state_reg != SER_IDLE)
		else $error("pins driven outside a transfer");
	a_no_read_ready_hi: assert property (@(posedge CLOCK) disable iff (RST)
		state_reg == SER_IDLE && frame_d_reg && !frame_s && sel_s && !ctrl_reg[CALSEL_BIT]
		&& ready_n_reg |=> state_reg == SER_IDLE && !SERIAL_DATA_PIN_OE)
		else $error("output read started with ready high");
	a_end_raises_ready: assert property (@(posedge CLOCK) disable iff (RST)
		out_done |=> WORD_READY_N && !SERIAL_DATA_PIN_OE && !SCLK_OE)
		else $error("read end did not raise ready and release pins");
	a_word_drops_ready: assert property (@(posedge CLOCK) disable iff (RST)
		SAMPLE_STROBE && !cal_busy_reg && !out_rd_reg && !cal_start
		&& ctrl_reg[MODE_MSB:MODE_LSB] != MODE_BACKGND |=> !WORD_READY_N)
		else $error("new word did not lower ready");
	a_word_discard: assert property (@(posedge CLOCK) disable iff (RST)
		out_rd_reg && SAMPLE_STROBE && !cal_busy_reg |=> $stable(word_reg))
		else $error("word replaced during output read");
	a_cal_ready_hi: assert property (@(posedge CLOCK) disable iff (RST)
		cal_busy_reg |-> WORD_READY_N)
		else $error("ready low while calibrating");
	a_ctrl_read_ready: assert property (@(posedge CLOCK) disable iff (RST)
		state_reg != SER_IDLE && !out_rd_reg && !SAMPLE_STROBE && !cal_start
		|=> $stable(WORD_READY_N))
		else $error("ctrl read changed ready");
	a_sclk_master: assert property (@(posedge CLOCK) disable iff (RST)
		SCLK_OE |-> $past(mode_s))
		else $error("serial clock driven in external mode");
	a_bg_rate: assert property (@(posedge CLOCK) disable iff (RST)
		SAMPLE_STROBE && !cal_busy_reg && !cal_start && !out_done
		&& ctrl_reg[MODE_MSB:MODE_LSB] == MODE_BACKGND && bg_cnt_reg != BG_DIVIDE - 3'h1
		|=> $stable(WORD_READY_N) && $stable(word_reg))
		else $error("background mode word out of rate");

endmodule : adc_readout
`default_nettype wire

/* logic/adc_readout_pkg.sv */
package adc_readout_pkg;

	// ==========================================================
	// word and bus widths
	localparam int          WORD_W        = 24;
	localparam int          AXI_ADDR_W    = 8;
	localparam int          AXI_DATA_W    = 32;
	localparam logic [4:0]  BITS_SHORT    = 5'h10;  // 16-bit output word
	localparam logic [4:0]  BITS_LONG     = 5'h18;  // 24-bit word, always for ctrl/cal

	// ==========================================================
	// timing: serial clock made by dividing the core clock
	localparam int          CLK_PERIOD_NS  = 100;
	localparam int          SCLK_PERIOD_NS = 800;
	localparam int          SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

	// ==========================================================
	// register byte addresses
	localparam logic [AXI_ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] ADDR_OFFS = 8'h04;
	localparam logic [AXI_ADDR_W-1:0] ADDR_GAIN = 8'h08;
	localparam logic [AXI_ADDR_W-1:0] ADDR_STAT = 8'h0C;
	localparam logic [AXI_ADDR_W-1:0] ADDR_DATA = 8'h10;

	// ==========================================================
	// control register fields and reset values
	localparam int          MODE_MSB       = 23;
	localparam int          MODE_LSB       = 21;
	localparam int          WL24_BIT       = 20;  // 1: 24-bit output word
	localparam int          CALSEL_BIT     = 19;  // 1: select-high read returns a cal reg
	localparam int          CALGAIN_BIT    = 18;  // 1: that cal reg is the gain one
	localparam logic [23:0] CTRL_RESET     = 24'h000000;
	localparam logic [23:0] OFFS_RESET     = 24'h000000;
	localparam logic [23:0] GAIN_RESET     = 24'h800000;
	localparam int          STAT_READY_BIT = 0;
	localparam int          STAT_CAL_BIT   = 1;
	localparam int          STAT_XFER_BIT  = 2;

	// ==========================================================
	// calibration modes and lengths in output periods
	localparam logic [2:0]  MODE_SELF      = 3'h1;
	localparam logic [2:0]  MODE_SYS_ZERO  = 3'h2;
	localparam logic [2:0]  MODE_SYS_FULL  = 3'h3;
	localparam logic [2:0]  MODE_SYS_OFFS  = 3'h4;
	localparam logic [2:0]  MODE_BACKGND   = 3'h5;
	localparam logic [3:0]  PER_SELF       = 4'h9;
	localparam logic [3:0]  PER_SYS        = 4'h4;
	localparam logic [3:0]  PER_SYS_OFFS   = 4'h9;
	localparam logic [2:0]  BG_DIVIDE      = 3'h6;

	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	typedef enum logic [1:0] {SER_IDLE, SER_LOW, SER_HIGH} ser_state_t;

endpackage : adc_readout_pkg

/* verification/host_serial_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ====
// host end of the serial read link
module host_serial_model (
	input  wire logic CLOCK,
	input  wire logic sclk_line,
	input  wire logic data_line,
	input  wire logic mode,
	output logic      frame_n,
	output logic      sclk_drive
);
	// frame idles high; our clock stands low between frames
	initial begin
		frame_n    = 1'h1;
		sclk_drive = 1'h0;
	end
	// frame held low for the whole word; mode 1 samples on each line rise,
	// mode 0 samples late in the high phase since the device sees our edges late
	task automatic read_word(input int nbits, output logic [31:0] val);
		int   i;
		int   t;
		logic p;
		val     = '0;
		frame_n <= 1'h0;
		if (!mode) #37;
		for (i = 0; i < nbits; i++) begin
			if (mode) begin
				t = 0;
				do begin
					p = sclk_line;
					@(negedge CLOCK);
					t++;
				end while (!(p === 1'h0 && sclk_line === 1'h1) && t < 40);
			end else begin
				#400 sclk_drive = 1'h1;
				#399;
			end
			val = {val[30:0], data_line};
			if (!mode) #1 sclk_drive = 1'h0;
		end
		repeat (12) @(negedge CLOCK);
		frame_n <= 1'h1;
	endtask : read_word
endmodule : host_serial_model
`default_nettype wire

/* verification/test_adc_serial_readout_calibration.sv */
`timescale 1ns/1ns
`default_nettype none
module test_adc_serial_readout_calibration
	import adc_readout_pkg::*;
;
	// ====
	// bench signals
	logic                  CLOCK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic                  AWREADY, WREADY, BVALID, ARREADY, RVALID, SAMPLE_STROBE;
	logic                  MODE_PIN, REGISTER_SELECT, SCLK_OUT, SCLK_OE, WORD_READY_N;
	logic                  SERIAL_DATA_PIN_OUT, SERIAL_DATA_PIN_OE, frame_n, sclk_drive;
	logic [AXI_ADDR_W-1:0] AWADDR, ARADDR;
	logic [AXI_DATA_W-1:0] WDATA, RDATA;
	logic [WORD_W-1:0]     SAMPLE_DATA, seed, w;
	logic [1:0]            BRESP, RRESP;
	logic [3:0]            WSTRB;
	logic [31:0]           exp_q[$], got_q[$];
	wire logic             sclk_line, data_line;
	int                    fails, cmp_count, k;
	int                    per [4] = '{9, 4, 4, 9};

	// released lines float up through the board pull-ups
	assign sclk_line = SCLK_OE ? SCLK_OUT : (MODE_PIN ? 1'h1 : sclk_drive);
	assign data_line = SERIAL_DATA_PIN_OE ? SERIAL_DATA_PIN_OUT : 1'h1;

	always #50 CLOCK = ~CLOCK;

	adc_readout u_dut (
		.CLOCK, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
		.BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
		.RREADY, .SAMPLE_DATA, .SAMPLE_STROBE, .MODE_PIN, .READ_FRAME_N(frame_n),
		.REGISTER_SELECT, .SCLK_IN(sclk_line), .SCLK_OUT, .SCLK_OE, .SERIAL_DATA_PIN_OUT,
		.SERIAL_DATA_PIN_OE, .WORD_READY_N
	);

	host_serial_model u_host (
		.CLOCK, .sclk_line, .data_line, .mode(MODE_PIN), .frame_n, .sclk_drive
	);

	// ====
	// helpers
	function automatic logic [23:0] lfsr(input logic [23:0] s);
		return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
	endfunction : lfsr

	task automatic check_val(input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : check_val

	task automatic check_flag(input logic e, input logic g);
		check_val({31'h0, e}, {31'h0, g});
	endtask : check_flag

	// results are compared on the falling edge, away from any driver update
	always @(negedge CLOCK) begin
		while (got_q.size() > 0) check_val(exp_q.pop_front(), got_q.pop_front());
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int t;
		t = 0;
		exp_q.push_back({30'h0, er});
		@(posedge CLOCK);
		AWADDR  <= a;
		WDATA   <= d;
		AWVALID <= 1'h1;
		WVALID  <= 1'h1;
		BREADY  <= 1'h1;
		do begin
			@(posedge CLOCK);
			t++;
			if (AWREADY === 1'h1) AWVALID <= 1'h0;
			if (WREADY === 1'h1) WVALID <= 1'h0;
		end while (BVALID !== 1'h1 && t < 50);
		check_flag(1'h1, BVALID);
		BREADY <= 1'h0;
		got_q.push_back({30'h0, BRESP});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int t;
		t = 0;
		exp_q.push_back(e);
		exp_q.push_back({30'h0, er});
		@(posedge CLOCK);
		ARADDR  <= a;
		ARVALID <= 1'h1;
		RREADY  <= 1'h1;
		do begin
			@(posedge CLOCK);
			t++;
			if (ARREADY === 1'h1) ARVALID <= 1'h0;
		end while (RVALID !== 1'h1 && t < 50);
		check_flag(1'h1, RVALID);
		RREADY <= 1'h0;
		got_q.push_back(RDATA);
		got_q.push_back({30'h0, RRESP});
	endtask : rd

	// n conversion words per call, each five cycles apart, spaced like a slow output rate
	task automatic strobe(input int n);
		repeat (n) begin
			seed = lfsr(seed);
			@(posedge CLOCK);
			SAMPLE_DATA   <= seed;
			SAMPLE_STROBE <= 1'h1;
			@(posedge CLOCK);
			SAMPLE_STROBE <= 1'h0;
			repeat (3) @(posedge CLOCK);
		end
	endtask : strobe

	// select is settled before the frame and held through it
	task automatic sread(input logic sel, input int n, input logic [31:0] e);
		logic [31:0] v;
		exp_q.push_back(e);
		@(posedge CLOCK);
		REGISTER_SELECT <= sel;
		repeat (4) @(posedge CLOCK);
		u_host.read_word(n, v);
		got_q.push_back(v);
	endtask : sread

	task automatic ready_is(input logic e);
		repeat (3) @(posedge CLOCK);
		check_flag(e, WORD_READY_N);
	endtask : ready_is

	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop

	// ====
	// watchdog: the run needs well under a millisecond
	initial begin
		#2000000;
		fails++;
		report_and_stop();
	end

	// ====
	// main sequence
	initial begin
		CLOCK = 1'h0;
		RST = 1'h1;
		{AWVALID, WVALID, BREADY, ARVALID, RREADY, SAMPLE_STROBE} = '0;
		{AWADDR, ARADDR, WDATA, SAMPLE_DATA} = '0;
		WSTRB = 4'hF;
		MODE_PIN = 1'h1;
		REGISTER_SELECT = 1'h1;
		seed = 24'h000035;
		repeat (10) @(posedge CLOCK);
		RST <= 1'h0;
		repeat (4) @(posedge CLOCK);
		check_flag(1'h0, SCLK_OE | SERIAL_DATA_PIN_OE);
		rd(ADDR_CTRL, {8'h0, CTRL_RESET}, RESP_OKAY);
		rd(ADDR_GAIN, {8'h0, GAIN_RESET}, RESP_OKAY);
		rd(8'h14, 32'h0, RESP_SLVERR);
		wr(ADDR_STAT, 32'h0, RESP_SLVERR);
		wr(ADDR_DATA, 32'h0, RESP_SLVERR);
		wr(ADDR_OFFS, 32'h00123456, RESP_OKAY);
		rd(ADDR_OFFS, 32'h00123456, RESP_OKAY);
		$display("test registers done");
		// a frame with nothing ready moves nothing; the line stays pulled up
		sread(1'h1, 1, 32'h1);
		ready_is(1'h1);
		$display("test idle frame done");
		// two unread words, newest wins; a word landing mid-read is lost
		strobe(2);
		ready_is(1'h0);
		rd(ADDR_STAT, 32'h1, RESP_OKAY);
		w = seed;
		fork
			sread(1'h1, 16, {16'h0, w[23:8]});
			begin
				repeat (60) @(posedge CLOCK);
				check_flag(1'h1, SCLK_OE & SERIAL_DATA_PIN_OE);
				strobe(1);
			end
		join
		ready_is(1'h1);
		check_flag(1'h0, SCLK_OE | SERIAL_DATA_PIN_OE);
		$display("test output read done");
		// control and coefficient reads are 24 bits and leave ready low
		strobe(1);
		w = seed;
		wr(ADDR_CTRL, 32'h00100000, RESP_OKAY);
		sread(1'h0, 24, 32'h00100000);
		wr(ADDR_CTRL, 32'h00180000, RESP_OKAY);
		sread(1'h1, 24, 32'h00123456);
		wr(ADDR_CTRL, 32'h001C0000, RESP_OKAY);
		sread(1'h1, 24, {8'h0, GAIN_RESET});
		ready_is(1'h0);
		wr(ADDR_CTRL, 32'h00100000, RESP_OKAY);
		sread(1'h1, 24, {8'h0, w});
		ready_is(1'h1);
		$display("test register reads done");
		// every calibration mode: ready high while running, low after its last period
		for (k = 1; k <= 4; k++) begin
			wr(ADDR_CTRL, {8'h0, k[2:0], 21'h0}, RESP_OKAY);
			ready_is(1'h1);
			rd(ADDR_STAT, 32'h2, RESP_OKAY);
			strobe(per[k - 1] - 1);
			ready_is(1'h1);
			strobe(1);
			ready_is(1'h0);
			rd((k == 3) ? ADDR_GAIN : ADDR_OFFS, {8'h0, seed}, RESP_OKAY);
		end
		sread(1'h1, 16, {16'h0, seed[23:8]});
		$display("test calibration done");
		// background mode passes one word in six
		wr(ADDR_CTRL, 32'h00A00000, RESP_OKAY);
		strobe(5);
		ready_is(1'h1);
		strobe(1);
		ready_is(1'h0);
		$display("test background done");
		// host-made serial clock at 800 ns, 24-bit word
		wr(ADDR_CTRL, 32'h00100000, RESP_OKAY);
		MODE_PIN <= 1'h0;
		strobe(1);
		// mid-word the data pin is ours but the clock pin is left to the host
		fork
			sread(1'h1, 24, {8'h0, seed});
			begin
				repeat (20) @(posedge CLOCK);
				check_flag(1'h0, SCLK_OE);
				check_flag(1'h1, SERIAL_DATA_PIN_OE);
			end
		join
		ready_is(1'h1);
		check_flag(1'h0, SCLK_OE);
		$display("test external clock done");
		repeat (3) @(posedge CLOCK);
		report_and_stop();
	end
endmodule : test_adc_serial_readout_calibration
`default_nettype wire
